// [src/srq_defines.vh]
`ifndef SRQ_DEFINES_VH
`define SRQ_DEFINES_VH

// ----------------------------------------------------------------------------
// Register selects on the command port
// ----------------------------------------------------------------------------
`define SRQ_SEL_COMM_COND   4'h0
`define SRQ_SEL_COMM_RISE   4'h1
`define SRQ_SEL_COMM_FALL   4'h2
`define SRQ_SEL_COMM_EVENT  4'h3
`define SRQ_SEL_COMM_ENABLE 4'h4
`define SRQ_SEL_HW1_COND    4'h5
`define SRQ_SEL_HW1_RISE    4'h6
`define SRQ_SEL_HW1_FALL    4'h7
`define SRQ_SEL_HW1_EVENT   4'h8
`define SRQ_SEL_HW1_ENABLE  4'h9
`define SRQ_SEL_STB         4'ha
`define SRQ_SEL_SRE         4'hb

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define SRQ_COMM_RX_BIT     0
`define SRQ_COMM_TX_BIT     1
`define SRQ_GRP_TOP_BIT     15
`define SRQ_HW1_COMM_BIT    6
`define SRQ_STB_HW1_BIT     0
`define SRQ_STB_HW2_BIT     1
`define SRQ_STB_UNUSED_BIT  2
`define SRQ_STB_QUES_BIT    3
`define SRQ_STB_MAV_BIT     4
`define SRQ_STB_ESB_BIT     5
`define SRQ_STB_RQS_BIT     6
`define SRQ_STB_OPER_BIT    7

// ----------------------------------------------------------------------------
// Reset values and masks
// ----------------------------------------------------------------------------
`define SRQ_GRP_RESET       16'h0000
`define SRQ_SRE_RESET       8'h00
`define SRQ_SRE_WMASK       8'hbf
`define SRQ_COND_MASK       16'h7fff

`endif

// [src/srq_status_group.v]
`include "srq_defines.vh"

// One status register group: condition, two transition filters,
// latching event register, enable register and summary message.
module srq_status_group (
   input  wire        clk_sys,      // System clock
   input  wire        rst,          // Asynchronous reset, active high
   input  wire [15:0] cond_in,      // Live condition bits
   input  wire        wr_rise,      // Write positive filter
   input  wire        wr_fall,      // Write negative filter
   input  wire        wr_enable,    // Write enable register
   input  wire [15:0] wdata,        // Write data
   input  wire        clr_event,    // Query or clear-status
   output reg  [15:0] condition,    // Condition register
   output reg  [15:0] rise_filter,  // Positive transition filter
   output reg  [15:0] fall_filter,  // Negative transition filter
   output reg  [15:0] event_latch,  // Event register
   output reg  [15:0] enable,       // Enable register
   output wire        summary       // Group summary message
);

   wire [15:0] cond_now;
   wire [15:0] caught;
   wire [15:0] next_event;

   // ----------------------------------------------------------------------
   // Transition detection
   // ----------------------------------------------------------------------
   // Top bit forced low so it can never latch an event
   assign cond_now   = cond_in & `SRQ_COND_MASK;
   assign caught     = (cond_now & ~condition & rise_filter) |
                       (~cond_now & condition & fall_filter);
   // A transition in the clearing cycle survives the clear
   assign next_event = (clr_event ? `SRQ_GRP_RESET : event_latch) | caught;
   // Summary is high while any enabled latched event stands
   assign summary    = |(event_latch & enable);

   // ----------------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------------
   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         condition   <= `SRQ_GRP_RESET;
         rise_filter <= `SRQ_GRP_RESET;
         fall_filter <= `SRQ_GRP_RESET;
         event_latch <= `SRQ_GRP_RESET;
         enable      <= `SRQ_GRP_RESET;
      end else begin
         condition   <= cond_now;
         event_latch <= next_event;
         if (wr_rise) begin
            rise_filter <= wdata;
         end
         if (wr_fall) begin
            fall_filter <= wdata;
         end
         if (wr_enable) begin
            enable <= wdata;
         end
      end
   end

endmodule

// [src/srq_status_top.v]
// Overview of operation
// - Communication group uses 16-bit condition, filters, event, enable and summary.
// - Communication condition bit 15 always reads zero.
// - Comm bit 1 is transmit link failure, bit 0 receive; others zero.
// - Controller reads conditions and reads/writes both transition filters.
// - First hardware group offers the same register access.
// - Event registers clear when queried and on clear-status.
// - Enable register holds the written value; writing zero clears it.
// - Seven sources each produce a summary message.
// - Status byte carries the listed summaries at bits 7,5,4,3,1,0; bit 2 zero.
// - Bit 6 is RQS on serial poll, master summary on byte query.
// - Only bits enabled in the service request enable register request service.
// - An enabled condition asserts SRQ and sets RQS.
// - Serial poll clears RQS until a new cause arises.
// - Every group summary feeds the status byte directly or indirectly.
// - Summary is 1 while enabled event bits are latched.
// - Service request enable ignores bit 6 on write.
`include "srq_defines.vh"

module srq_status_top (
   input  wire        clk_sys,       // System clock, 10 MHz
   input  wire        rst,           // Asynchronous reset, active high
   input  wire        tx_link_fail,  // Transmit analyzer link failure pin
   input  wire        rx_link_fail,  // Receive analyzer link failure pin
   input  wire [14:0] hw1_cond_pin,  // First hardware group condition pins
   input  wire        oper_summary,  // Operation group summary
   input  wire        esb_summary,   // Standard event summary
   input  wire        mav_summary,   // Output queue message available
   input  wire        ques_summary,  // Questionable group summary
   input  wire        hw2_summary,   // Second hardware group summary
   input  wire        cmd_valid,     // Command or query strobe
   input  wire        cmd_write,     // 1 write, 0 query
   input  wire [3:0]  cmd_sel,       // Register select
   input  wire [15:0] cmd_wdata,     // Integer written
   input  wire        clear_status,  // Clear-status common command
   input  wire        spoll_req,     // Serial poll strobe
   output reg         rsp_valid,     // Query answer strobe
   output reg  [15:0] rsp_data,      // Query answer value
   output reg         spoll_valid,   // Serial poll answer strobe
   output reg  [7:0]  spoll_data,    // Serial poll status byte
   output reg         srq_out,       // Bus SRQ level when driven
   output reg         srq_oe         // Bus SRQ drive enable
);

   // ----------------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------------
   // Seventeen pins: 15 hardware bits then receive and transmit link.
   localparam NPIN = 17;

   wire [NPIN-1:0] pin_raw;
   reg  [NPIN-1:0] pin_s1;
   reg  [NPIN-1:0] pin_s2;
   reg  [NPIN-1:0] pin_s3;
   reg  [NPIN-1:0] pin_clean;

   assign pin_raw = {tx_link_fail, rx_link_fail, hw1_cond_pin};

   // Three stages; a bit only moves when the last two stages agree,
   // which costs a cycle of latency but rejects single-cycle glitches
   genvar gi;
   generate
      for (gi = 0; gi < NPIN; gi = gi + 1) begin : g_pin
         always @(posedge clk_sys or posedge rst) begin
            if (rst) begin
               pin_s1[gi]    <= 1'b0;
               pin_s2[gi]    <= 1'b0;
               pin_s3[gi]    <= 1'b0;
               pin_clean[gi] <= 1'b0;
            end else begin
               pin_s1[gi] <= pin_raw[gi];
               pin_s2[gi] <= pin_s1[gi];
               pin_s3[gi] <= pin_s2[gi];
               if (pin_s2[gi] == pin_s3[gi]) begin
                  pin_clean[gi] <= pin_s3[gi];
               end
            end
         end
      end
   endgenerate

   // ----------------------------------------------------------------------
   // Condition vectors
   // ----------------------------------------------------------------------
   wire [15:0] comm_cond_in;
   wire [15:0] hw1_cond_in;
   wire        comm_summary;
   wire        hw1_summary;

   // Only the two link bits exist; the rest stay low
   assign comm_cond_in = {14'h0000, pin_clean[16], pin_clean[15]};
   // Bit 6 of the hardware group carries the communication summary,
   // so that group reaches the status byte indirectly
   assign hw1_cond_in  = {1'b0, pin_clean[14:7], comm_summary,
                          pin_clean[5:0]};

   // ----------------------------------------------------------------------
   // Command decode
   // ----------------------------------------------------------------------
   wire rd_cmd;
   wire wr_cmd;
   wire comm_wr_rise;
   wire comm_wr_fall;
   wire comm_wr_enable;
   wire comm_clr;
   wire hw1_wr_rise;
   wire hw1_wr_fall;
   wire hw1_wr_enable;
   wire hw1_clr;
   wire sre_wr;

   assign rd_cmd         = cmd_valid & ~cmd_write;
   assign wr_cmd         = cmd_valid & cmd_write;
   assign comm_wr_rise   = wr_cmd & (cmd_sel == `SRQ_SEL_COMM_RISE);
   assign comm_wr_fall   = wr_cmd & (cmd_sel == `SRQ_SEL_COMM_FALL);
   assign comm_wr_enable = wr_cmd & (cmd_sel == `SRQ_SEL_COMM_ENABLE);
   assign hw1_wr_rise    = wr_cmd & (cmd_sel == `SRQ_SEL_HW1_RISE);
   assign hw1_wr_fall    = wr_cmd & (cmd_sel == `SRQ_SEL_HW1_FALL);
   assign hw1_wr_enable  = wr_cmd & (cmd_sel == `SRQ_SEL_HW1_ENABLE);
   assign sre_wr         = wr_cmd & (cmd_sel == `SRQ_SEL_SRE);
   // Querying an event register empties it, as does clear-status
   assign comm_clr = clear_status |
                     (rd_cmd & (cmd_sel == `SRQ_SEL_COMM_EVENT));
   assign hw1_clr  = clear_status |
                     (rd_cmd & (cmd_sel == `SRQ_SEL_HW1_EVENT));

   // ----------------------------------------------------------------------
   // Register groups
   // ----------------------------------------------------------------------
   wire [15:0] comm_condition;
   wire [15:0] comm_rise_filter;
   wire [15:0] comm_fall_filter;
   wire [15:0] comm_event_latch;
   wire [15:0] comm_event_enable;
   wire [15:0] hw1_condition;
   wire [15:0] hw1_rise_filter;
   wire [15:0] hw1_fall_filter;
   wire [15:0] hw1_event_latch;
   wire [15:0] hw1_event_enable;

   // Communication group
   srq_status_group u_comm (
      .clk_sys     (clk_sys),
      .rst         (rst),
      .cond_in     (comm_cond_in),
      .wr_rise     (comm_wr_rise),
      .wr_fall     (comm_wr_fall),
      .wr_enable   (comm_wr_enable),
      .wdata       (cmd_wdata),
      .clr_event   (comm_clr),
      .condition   (comm_condition),
      .rise_filter (comm_rise_filter),
      .fall_filter (comm_fall_filter),
      .event_latch (comm_event_latch),
      .enable      (comm_event_enable),
      .summary     (comm_summary)
   );

   // First hardware group, same structure
   srq_status_group u_hw1 (
      .clk_sys     (clk_sys),
      .rst         (rst),
      .cond_in     (hw1_cond_in),
      .wr_rise     (hw1_wr_rise),
      .wr_fall     (hw1_wr_fall),
      .wr_enable   (hw1_wr_enable),
      .wdata       (cmd_wdata),
      .clr_event   (hw1_clr),
      .condition   (hw1_condition),
      .rise_filter (hw1_rise_filter),
      .fall_filter (hw1_fall_filter),
      .event_latch (hw1_event_latch),
      .enable      (hw1_event_enable),
      .summary     (hw1_summary)
   );

   // ----------------------------------------------------------------------
   // Status byte and service request enable
   // ----------------------------------------------------------------------
   reg  [7:0] sre;
   reg        rqs;
   reg        mss_prev;
   wire [7:0] stb_base;
   wire       mss;
   wire       new_cause;
   wire       next_rqs;

   // Bit 6 is filled in by whichever reader asks; the remaining groups
   // arrive as summaries from outside this block, except bit 0 from the first hardware group
   assign stb_base = {oper_summary,
                      1'b0,
                      esb_summary,
                      mav_summary,
                      ques_summary,
                      1'b0,
                      hw2_summary,
                      hw1_summary};
   // Only enabled bits count, and bit 6 is never among them
   assign mss       = |(stb_base & sre & `SRQ_SRE_WMASK);
   // A request starts on a fresh rise of the master summary, so a
   // condition that merely persists does not re-arm after a poll
   assign new_cause = mss & ~mss_prev;
   // New cause wins over a poll in the same cycle
   assign next_rqs  = new_cause | (rqs & ~spoll_req);

   // Enable register write, bit 6 dropped on the way in
   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         sre <= `SRQ_SRE_RESET;
      end else if (sre_wr) begin
         sre <= cmd_wdata[7:0] & `SRQ_SRE_WMASK;
      end
   end

   // Request flag tracking
   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         rqs      <= 1'b0;
         mss_prev <= 1'b0;
      end else begin
         rqs      <= next_rqs;
         mss_prev <= mss;
      end
   end

   // ----------------------------------------------------------------------
   // Bus request line
   // ----------------------------------------------------------------------
   // SRQ is open-drain: the level driven is always low, the enable
   // follows the request flag
   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         srq_out <= 1'b0;
         srq_oe  <= 1'b0;
      end else begin
         srq_out <= 1'b0;
         srq_oe  <= next_rqs;
      end
   end

   // ----------------------------------------------------------------------
   // Serial poll answer
   // ----------------------------------------------------------------------
   // The byte carries the flag as it stood before this poll cleared it
   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         spoll_valid <= 1'b0;
         spoll_data  <= 8'h00;
      end else begin
         spoll_valid <= spoll_req;
         if (spoll_req) begin
            spoll_data <= stb_base;
            spoll_data[`SRQ_STB_RQS_BIT] <= rqs;
         end
      end
   end

   // ----------------------------------------------------------------------
   // Query answer
   // ----------------------------------------------------------------------
   reg [15:0] next_rsp;

   // Read mux; unknown selects answer zero, and writes give no answer
   always @* begin
      next_rsp = 16'h0000;
      case (cmd_sel)
         `SRQ_SEL_COMM_COND:   next_rsp = comm_condition;
         `SRQ_SEL_COMM_RISE:   next_rsp = comm_rise_filter;
         `SRQ_SEL_COMM_FALL:   next_rsp = comm_fall_filter;
         `SRQ_SEL_COMM_EVENT:  next_rsp = comm_event_latch;
         `SRQ_SEL_COMM_ENABLE: next_rsp = comm_event_enable;
         `SRQ_SEL_HW1_COND:    next_rsp = hw1_condition;
         `SRQ_SEL_HW1_RISE:    next_rsp = hw1_rise_filter;
         `SRQ_SEL_HW1_FALL:    next_rsp = hw1_fall_filter;
         `SRQ_SEL_HW1_EVENT:   next_rsp = hw1_event_latch;
         `SRQ_SEL_HW1_ENABLE:  next_rsp = hw1_event_enable;
         `SRQ_SEL_STB: begin
            next_rsp = {8'h00, stb_base};
            next_rsp[`SRQ_STB_RQS_BIT] = mss;
         end
         `SRQ_SEL_SRE:         next_rsp = {8'h00, sre};
         default:              next_rsp = 16'h0000;
      endcase
   end

   // Answer register, one cycle after the query strobe
   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         rsp_valid <= 1'b0;
         rsp_data  <= 16'h0000;
      end else begin
         rsp_valid <= rd_cmd;
         if (rd_cmd) begin
            rsp_data <= next_rsp;
         end
      end
   end

endmodule

// [testbench/srq_status_props.sv]
`include "srq_defines.vh"

module srq_status_props (
   input wire        clk_sys,      // Clock
   input wire        rst,          // Reset
   input wire        tx_link_fail, // Pin
   input wire        rx_link_fail, // Pin
   input wire [14:0] hw1_cond_pin, // Pins
   input wire        oper_summary, // Summary in
   input wire        esb_summary,  // Summary in
   input wire        mav_summary,  // Summary in
   input wire        ques_summary, // Summary in
   input wire        hw2_summary,  // Summary in
   input wire        cmd_valid,    // Strobe
   input wire        cmd_write,    // Write flag
   input wire [3:0]  cmd_sel,      // Select
   input wire [15:0] cmd_wdata,    // Data
   input wire        clear_status, // Clear-status
   input wire        spoll_req,    // Poll strobe
   input wire        rsp_valid,    // Answer strobe
   input wire [15:0] rsp_data,     // Answer
   input wire        spoll_valid,  // Poll answer strobe
   input wire [7:0]  spoll_data,   // Poll byte
   input wire        srq_out,      // SRQ level
   input wire        srq_oe        // SRQ drive
);
   timeunit 1ns;
   timeprecision 1ns;

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);

   // ------------------------------------------------------------
   // Query and poll steps
   // ------------------------------------------------------------
   sequence s_query(logic [3:0] s);
      cmd_valid && !cmd_write && cmd_sel == s ##1 rsp_valid;
   endsequence
   sequence s_poll;
      spoll_req ##1 spoll_valid;
   endsequence

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   a_query_answer: assert property (cmd_valid && !cmd_write |=> rsp_valid)
      else $error("query not answered next cycle");
   a_no_stray_answer: assert property (!(cmd_valid && !cmd_write) |=> !rsp_valid)
      else $error("answer without query");
   a_comm_cond_bits: assert property (s_query(`SRQ_SEL_COMM_COND) |-> rsp_data[15:2] == 14'h0000)
      else $error("comm condition unused bits set");
   a_hw1_top_bit: assert property (s_query(`SRQ_SEL_HW1_COND) |-> !rsp_data[15])
      else $error("hw1 condition bit 15 set");
   a_stb_layout: assert property (s_query(`SRQ_SEL_STB) |-> rsp_data[15:8] == 8'h00 && !rsp_data[2])
      else $error("status byte unused bits set");
   a_sre_no_bit6: assert property (s_query(`SRQ_SEL_SRE) |-> rsp_data[15:8] == 8'h00 && !rsp_data[6])
      else $error("request enable holds bit 6");
   a_poll_answer: assert property (spoll_req |=> spoll_valid)
      else $error("poll not answered");
   a_rqs_in_poll: assert property (s_poll |-> spoll_data[6] == $past(srq_oe))
      else $error("poll bit 6 differs from request state");
   a_poll_unused: assert property (s_poll |-> !spoll_data[2])
      else $error("poll byte bit 2 set");
   a_srq_level: assert property (srq_out == 1'b0)
      else $error("SRQ driven high");
endmodule

bind srq_status_top srq_status_props u_props (
   .clk_sys(clk_sys), .rst(rst), .tx_link_fail(tx_link_fail), .rx_link_fail(rx_link_fail),
   .hw1_cond_pin(hw1_cond_pin), .oper_summary(oper_summary), .esb_summary(esb_summary),
   .mav_summary(mav_summary), .ques_summary(ques_summary), .hw2_summary(hw2_summary),
   .cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_sel(cmd_sel), .cmd_wdata(cmd_wdata),
   .clear_status(clear_status), .spoll_req(spoll_req), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
   .spoll_valid(spoll_valid), .spoll_data(spoll_data), .srq_out(srq_out), .srq_oe(srq_oe)
);

// [testbench/srq_ctl_model.sv]
module srq_ctl_model (
   input  wire         clk_sys,      // Clock
   input  wire         srq_out,      // Device SRQ level
   input  wire         srq_oe,       // Device SRQ drive
   output logic        cmd_valid,    // Strobe
   output logic        cmd_write,    // Write flag
   output logic [3:0]  cmd_sel,      // Select
   output logic [15:0] cmd_wdata,    // Data
   output logic        clear_status, // Clear-status
   output logic        spoll_req,    // Poll strobe
   output wire         srq_line      // Bus SRQ wire
);
   timeunit 1ns;
   timeprecision 1ns;

   // Open-drain SRQ with bus pull-up
   assign srq_line = srq_oe ? srq_out : 1'b1;

   initial begin
      cmd_valid = 1'b0;
      cmd_write = 1'b0;
      cmd_sel = 4'h0;
      cmd_wdata = 16'h0000;
      clear_status = 1'b0;
      spoll_req = 1'b0;
   end

   // One command held for the single edge that takes it
   task send(input logic w, input logic [3:0] s, input logic [15:0] d);
      @(posedge clk_sys);
      cmd_valid <= 1'b1;
      cmd_write <= w;
      cmd_sel <= s;
      cmd_wdata <= d;
      @(posedge clk_sys);
      cmd_valid <= 1'b0;
      cmd_wdata <= ~d; // Released data must not look valid
   endtask

   // Clear-status common command
   task cls;
      @(posedge clk_sys);
      clear_status <= 1'b1;
      @(posedge clk_sys);
      clear_status <= 1'b0;
   endtask

   task poll;
      @(posedge clk_sys);
      spoll_req <= 1'b1;
      @(posedge clk_sys);
      spoll_req <= 1'b0;
   endtask
endmodule

// [testbench/srq_status_top_tb.sv]
`include "srq_defines.vh"

module srq_status_top_tb;
   timeunit 1ns;
   timeprecision 1ns;

   logic        clk_sys, rst, tx, rx;
   logic [14:0] pin;
   logic [7:0]  ext, m;
   logic [31:0] v;
   wire         cmd_valid, cmd_write, clear_status, spoll_req, rsp_valid, spoll_valid, srq_out, srq_oe, srq_line;
   wire  [3:0]  cmd_sel;
   wire  [15:0] cmd_wdata, rsp_data;
   wire  [7:0]  spoll_data;
   integer      seed = 32'hc3638985;
   integer      n_fail = 0;
   integer      samples_checked = 0;
   integer      i, k;
   logic [15:0] rq[$];
   logic [7:0]  sq[$];
   logic [3:0]  sels[6] = '{`SRQ_SEL_COMM_RISE, `SRQ_SEL_COMM_FALL, `SRQ_SEL_COMM_ENABLE,
                            `SRQ_SEL_HW1_RISE, `SRQ_SEL_HW1_FALL, `SRQ_SEL_HW1_ENABLE};
   int          bl[5] = '{7, 5, 4, 3, 1};

   srq_status_top dut (.clk_sys(clk_sys), .rst(rst), .tx_link_fail(tx), .rx_link_fail(rx),
      .hw1_cond_pin(pin), .oper_summary(ext[7]), .esb_summary(ext[5]), .mav_summary(ext[4]),
      .ques_summary(ext[3]), .hw2_summary(ext[1]), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
      .cmd_sel(cmd_sel), .cmd_wdata(cmd_wdata), .clear_status(clear_status), .spoll_req(spoll_req),
      .rsp_valid(rsp_valid), .rsp_data(rsp_data), .spoll_valid(spoll_valid), .spoll_data(spoll_data),
      .srq_out(srq_out), .srq_oe(srq_oe));

   srq_ctl_model ctl (.clk_sys(clk_sys), .srq_out(srq_out), .srq_oe(srq_oe), .cmd_valid(cmd_valid),
      .cmd_write(cmd_write), .cmd_sel(cmd_sel), .cmd_wdata(cmd_wdata), .clear_status(clear_status),
      .spoll_req(spoll_req), .srq_line(srq_line));

   // ------------------------------------------------------------
   // Clock, watchdog, report
   // ------------------------------------------------------------
   initial begin
      forever #50 clk_sys = ~clk_sys;
   end

   initial begin
      repeat (20000) @(posedge clk_sys);
      n_fail = n_fail + 1;
      end_sim;
   end

   task end_sim;
      $display("checked %0d, mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   // ------------------------------------------------------------
   // Compare tasks
   // ------------------------------------------------------------
   task chk16(input logic [15:0] e, input logic [15:0] g);
      samples_checked = samples_checked + 1;
      if (g !== e) begin
         n_fail = n_fail + 1;
         $display("BAD %0t answer %h want %h", $time, g, e);
      end
   endtask

   task chk8(input logic [7:0] e, input logic [7:0] g);
      samples_checked = samples_checked + 1;
      if (g !== e) begin
         n_fail = n_fail + 1;
         $display("BAD %0t poll %h want %h", $time, g, e);
      end
   endtask

   // Bus wire is sampled mid-cycle, well away from the edge
   task chkl(input logic e);
      @(negedge clk_sys);
      samples_checked = samples_checked + 1;
      if (srq_line !== e) begin
         n_fail = n_fail + 1;
         $display("BAD %0t SRQ wire %b want %b", $time, srq_line, e);
      end
   endtask

   // Answers are matched against the oldest note
   always @(posedge clk_sys) begin
      if (rsp_valid === 1'b1) begin
         if (rq.size() == 0) begin
            n_fail = n_fail + 1;
            $display("BAD %0t unexpected answer", $time);
         end else
            chk16(rq.pop_front(), rsp_data);
      end
      if (spoll_valid === 1'b1) begin
         if (sq.size() == 0) begin
            n_fail = n_fail + 1;
            $display("BAD %0t unexpected poll answer", $time);
         end else
            chk8(sq.pop_front(), spoll_data);
      end
   end

   // ------------------------------------------------------------
   // Driver tasks
   // ------------------------------------------------------------
   task q(input logic [3:0] s, input logic [15:0] e);
      rq.push_back(e);
      ctl.send(1'b0, s, 16'h0000);
   endtask

   task w(input logic [3:0] s, input logic [15:0] d);
      ctl.send(1'b1, s, d);
   endtask

   task p(input logic [7:0] e);
      sq.push_back(e);
      ctl.poll;
   endtask

   task idle(input integer n);
      repeat (n) @(posedge clk_sys);
   endtask

   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial begin
      clk_sys = 1'b0;
      rst = 1'b1;
      tx = 1'b0;
      rx = 1'b0;
      pin = 15'h0000;
      ext = 8'h00;
      repeat (3) @(posedge clk_sys);
      rst <= 1'b0;
      for (i = 0; i < 16; i++) q(i[3:0], 16'h0000);
      $display("done: reset values");
      for (i = 0; i < 6; i++) begin
         v = $random(seed) & 32'h7fff;
         w(sels[i], v[15:0]);
         q(sels[i], v[15:0]);
      end
      for (i = 0; i < 6; i++) begin
         w(sels[i], 16'h0000);
         q(sels[i], 16'h0000);
      end
      w(`SRQ_SEL_SRE, 16'h00ff);
      q(`SRQ_SEL_SRE, 16'h00bf);
      w(`SRQ_SEL_COMM_COND, 16'hffff);
      q(`SRQ_SEL_COMM_COND, 16'h0000);
      w(`SRQ_SEL_SRE, 16'h0000);
      v = $random(seed);
      @(posedge clk_sys);
      pin <= v[14:0];
      idle(8);
      q(`SRQ_SEL_HW1_COND, {1'b0, pin[14:7], 1'b0, pin[5:0]});
      $display("done: register access");
      // Each externally fed summary bit (7,5,4,3,1): blocked, then enabled, then polled
      for (k = 0; k < 5; k++) begin
         m = 8'h01 << bl[k];
         @(posedge clk_sys);
         ext <= m;
         idle(2);
         q(`SRQ_SEL_STB, {8'h00, m});
         chkl(1'b1);
         w(`SRQ_SEL_SRE, {8'h00, m});
         idle(3);
         q(`SRQ_SEL_STB, {8'h00, m | 8'h40});
         chkl(1'b0);
         p(m | 8'h40);
         p(m);
         chkl(1'b1);
         @(posedge clk_sys);
         ext <= 8'h00;
         w(`SRQ_SEL_SRE, 16'h0000);
      end
      $display("done: status byte");
      w(`SRQ_SEL_COMM_RISE, 16'h0002);
      w(`SRQ_SEL_COMM_FALL, 16'h0001);
      @(posedge clk_sys);
      tx <= 1'b1;
      rx <= 1'b1;
      idle(8);
      q(`SRQ_SEL_COMM_COND, 16'h0003);
      q(`SRQ_SEL_COMM_EVENT, 16'h0002);
      q(`SRQ_SEL_COMM_EVENT, 16'h0000);
      @(posedge clk_sys);
      tx <= 1'b0;
      rx <= 1'b0;
      idle(8);
      @(posedge clk_sys);
      rx <= 1'b1;
      idle(8);
      q(`SRQ_SEL_COMM_EVENT, 16'h0001);
      @(posedge clk_sys);
      rx <= 1'b0;
      idle(8);
      ctl.cls;
      idle(2);
      q(`SRQ_SEL_COMM_EVENT, 16'h0000);
      $display("done: transitions");
      // Chain: comm summary into hw1 bit 6, hw1 summary into byte bit 0
      w(`SRQ_SEL_COMM_ENABLE, 16'h0002);
      w(`SRQ_SEL_HW1_RISE, 16'h0040);
      w(`SRQ_SEL_HW1_ENABLE, 16'h0040);
      w(`SRQ_SEL_SRE, 16'h0001);
      @(posedge clk_sys);
      tx <= 1'b1;
      idle(14);
      chkl(1'b0);
      q(`SRQ_SEL_STB, 16'h0041);
      q(`SRQ_SEL_HW1_COND, {1'b0, pin[14:7], 1'b1, pin[5:0]});
      p(8'h41);
      p(8'h01);
      chkl(1'b1);
      q(`SRQ_SEL_HW1_EVENT, 16'h0040);
      q(`SRQ_SEL_STB, 16'h0000);
      $display("done: service request");
      for (i = 0; i < 20 && (rq.size() != 0 || sq.size() != 0); i++) @(posedge clk_sys);
      if (rq.size() != 0 || sq.size() != 0) begin
         n_fail = n_fail + 1;
         $display("BAD %0t answers missing", $time);
      end
      end_sim;
   end
endmodule
